// ### hdl/czj_zone.sv
`timescale 1ns/1ps
`include "czj_defines.svh"

module czj_zone #(
   parameter int unsigned TICK_CYCLES = `CZJ_TICK_CYCLES
) (
   input  wire logic                ref_clk,
   input  wire logic                nrst,
   input  wire logic                clk_en,
   input  wire logic                sensor_pin,
   input  wire logic                sensor_act_high,
   input  wire logic                run_req,
   input  wire czj_pkg::czj_jog_s   jog,
   input  wire czj_pkg::czj_timers_s timers,
   output logic                     motor_fwd,
   output logic                     motor_rev,
   output logic                     jam_flag,
   output czj_pkg::czj_state_e      zone_state
);

   // ***************************************************************
   // declarations
   // ***************************************************************
   logic [1:0]               sync_reg;
   logic [1:0]               sync_next;
   logic                     tick;
   logic                     sens_blk;
   logic                     jog_on;
   czj_pkg::czj_state_e      st_reg;
   czj_pkg::czj_state_e      st_next;
   logic [`CZJ_TMR_W-1:0]    cnt_reg;
   logic [`CZJ_TMR_W-1:0]    cnt_next;
   logic [`CZJ_TMR_W-1:0]    cur_lim;
   logic [`CZJ_TMR_W-1:0]    cnt_inc;
   logic                     hit;
   logic                     fwd_reg;
   logic                     fwd_next;
   logic                     rev_reg;
   logic                     rev_next;
   logic                     jam_reg;
   logic                     jam_next;

   // ***************************************************************
   // step tick
   // ***************************************************************
   czj_tick_gen #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_tick (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .clk_en  (clk_en),
      .tick    (tick)
   );

   // ***************************************************************
   // sensor synchroniser
   // ***************************************************************
   // pin is asynchronous; only the second stage is ever read
   always_comb begin
      sync_next = {sync_reg[0], sensor_pin};
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         sync_reg <= `CZJ_SYNC_RST;
      end else if (clk_en) begin
         sync_reg <= sync_next;
      end
   end

   // polarity applied after the second stage
   assign sens_blk = sensor_act_high ? sync_reg[1] : ~sync_reg[1];
   assign jog_on   = jog.fwd | jog.rev;

   // ***************************************************************
   // zone timer
   // ***************************************************************
   // one counter serves whichever duration the state needs
   always_comb begin
      case (st_reg)
         czj_pkg::CZJ_FWD_BLOCK: cur_lim = timers.jam_set;
         czj_pkg::CZJ_CLEAR:     cur_lim = timers.clear_set;
         czj_pkg::CZJ_UNJAM:     cur_lim = timers.unjam_set;
         default:                cur_lim = `CZJ_TMR_ZERO;
      endcase
   end

   assign cnt_inc = cnt_reg + `CZJ_TMR_ONE;
   // expiry lands on a tick, so resolution is one 0.2 s step
   assign hit = tick && (cur_lim != `CZJ_TMR_ZERO) &&
                (cnt_inc >= cur_lim);

   // ***************************************************************
   // zone sequencer
   // ***************************************************************
   always_comb begin
      st_next  = st_reg;
      cnt_next = cnt_reg;
      if (tick && cur_lim != `CZJ_TMR_ZERO) begin
         cnt_next = cnt_inc;
      end
      case (st_reg)
         czj_pkg::CZJ_IDLE: begin
            if (!jog_on && run_req) begin
               st_next = sens_blk ? czj_pkg::CZJ_FWD_BLOCK
                                  : czj_pkg::CZJ_FWD_WAIT;
            end
         end
         czj_pkg::CZJ_FWD_WAIT: begin
            if (jog_on || !run_req) begin
               st_next = czj_pkg::CZJ_IDLE;
            end else if (sens_blk) begin
               st_next = czj_pkg::CZJ_FWD_BLOCK;
            end
         end
         czj_pkg::CZJ_FWD_BLOCK: begin
            // jog hands the motor to the host; detection stops
            if (jog_on) begin
               st_next = czj_pkg::CZJ_IDLE;
            end else if (!sens_blk) begin
               st_next = czj_pkg::CZJ_CLEAR;
            end else if (hit) begin
               // zero jam setting never hits: runs on forward
               if (timers.unjam_set != `CZJ_TMR_ZERO) begin
                  st_next = czj_pkg::CZJ_UNJAM;
               end else begin
                  st_next = czj_pkg::CZJ_JAMMED;
               end
            end
         end
         czj_pkg::CZJ_CLEAR: begin
            if (jog_on) begin
               st_next = czj_pkg::CZJ_IDLE;
            end else if (timers.clear_set == `CZJ_TMR_ZERO) begin
               // no clear time: next tray on the sensor stops us
               if (sens_blk) begin
                  st_next = czj_pkg::CZJ_IDLE;
               end
            end else if (sens_blk) begin
               st_next = czj_pkg::CZJ_FWD_BLOCK;
            end else if (hit) begin
               st_next = czj_pkg::CZJ_IDLE;
            end
         end
         czj_pkg::CZJ_UNJAM: begin
            if (jog_on) begin
               st_next = czj_pkg::CZJ_IDLE;
            end else if (!sens_blk) begin
               st_next = czj_pkg::CZJ_FWD_WAIT;
            end else if (hit) begin
               st_next = czj_pkg::CZJ_JAMMED;
            end
         end
         czj_pkg::CZJ_JAMMED: begin
            // cleared only by removing the tray by hand
            if (!sens_blk) begin
               st_next = czj_pkg::CZJ_IDLE;
            end
         end
         default: begin
            st_next = czj_pkg::CZJ_IDLE;
         end
      endcase
      if (st_next != st_reg) begin
         cnt_next = `CZJ_TMR_ZERO;
      end
   end

   // motor and flag follow the next state so outputs are flops
   always_comb begin
      jam_next = (st_next == czj_pkg::CZJ_UNJAM) ||
                 (st_next == czj_pkg::CZJ_JAMMED);
      fwd_next = jog.fwd ||
                 (!jog_on && (st_next == czj_pkg::CZJ_FWD_WAIT ||
                              st_next == czj_pkg::CZJ_FWD_BLOCK ||
                              st_next == czj_pkg::CZJ_CLEAR));
      rev_next = (jog.rev && !jog.fwd) ||
                 (!jog_on && st_next == czj_pkg::CZJ_UNJAM);
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         st_reg  <= czj_pkg::CZJ_IDLE;
         cnt_reg <= `CZJ_TMR_ZERO;
         fwd_reg <= 1'b0;
         rev_reg <= 1'b0;
         jam_reg <= 1'b0;
      end else if (clk_en) begin
         st_reg  <= st_next;
         cnt_reg <= cnt_next;
         fwd_reg <= fwd_next;
         rev_reg <= rev_next;
         jam_reg <= jam_next;
      end
   end

   assign motor_fwd  = fwd_reg;
   assign motor_rev  = rev_reg;
   assign jam_flag   = jam_reg;
   assign zone_state = st_reg;

   // ***************************************************************
   // assertions
   // ***************************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   AST_JAM_ON_EXPIRE: assert property (
      clk_en && st_reg == czj_pkg::CZJ_FWD_BLOCK && sens_blk &&
      !jog_on && hit |=> jam_flag && !motor_fwd)
      else $error("jam timer expiry did not raise jam");

   AST_JAM_ZERO_OFF: assert property (
      st_reg == czj_pkg::CZJ_FWD_BLOCK && timers.jam_set == 8'h00 &&
      sens_blk && !jog_on && clk_en |=> !jam_flag && motor_fwd)
      else $error("zero jam setting still detected jam");

   AST_UNJAM_REV: assert property (
      st_reg == czj_pkg::CZJ_UNJAM && !jog_on && $past(!jog_on)
      |-> motor_rev && !motor_fwd)
      else $error("unjam state without reverse motor");

   AST_UNJAM_RECOVER: assert property (
      clk_en && st_reg == czj_pkg::CZJ_UNJAM && !sens_blk && !jog_on
      |=> st_reg == czj_pkg::CZJ_FWD_WAIT && motor_fwd && !motor_rev)
      else $error("clear during unjam did not resume forward");

   AST_UNJAM_FAIL: assert property (
      clk_en && st_reg == czj_pkg::CZJ_UNJAM && sens_blk && hit &&
      !jog_on |=> st_reg == czj_pkg::CZJ_JAMMED && jam_flag &&
      !motor_fwd && !motor_rev)
      else $error("unjam expiry did not stop and flag");

   AST_UNJAM_ZERO: assert property (
      clk_en && st_reg == czj_pkg::CZJ_FWD_BLOCK && sens_blk && hit &&
      !jog_on && timers.unjam_set == 8'h00
      |=> st_reg == czj_pkg::CZJ_JAMMED && !motor_rev)
      else $error("zero unjam setting still reversed");

   AST_CLEAR_ZERO_STOP: assert property (
      clk_en && st_reg == czj_pkg::CZJ_CLEAR && !jog_on &&
      timers.clear_set == 8'h00 && sens_blk
      |=> !motor_fwd && st_reg == czj_pkg::CZJ_IDLE)
      else $error("clear zero did not stop on second tray");

   AST_JOG_NO_JAM: assert property (
      clk_en && jog_on && st_reg != czj_pkg::CZJ_JAMMED
      |=> st_reg != czj_pkg::CZJ_UNJAM && !jam_flag)
      else $error("jam logic active under jog");

   AST_TIMER_IDLE: assert property (
      st_reg == czj_pkg::CZJ_IDLE && $past(st_reg) ==
      czj_pkg::CZJ_IDLE |-> cnt_reg == 8'h00)
      else $error("timer not cleared while idle");

   AST_TIMER_STEP: assert property (
      clk_en && !tick && st_reg == $past(st_reg) ##1
      st_reg == $past(st_reg) |-> cnt_reg == $past(cnt_reg))
      else $error("timer moved without a tick");

   COV_JAM_STOP: cover property (
      st_reg == czj_pkg::CZJ_UNJAM ##1 st_reg == czj_pkg::CZJ_JAMMED);
   COV_UNJAM_OK: cover property (
      st_reg == czj_pkg::CZJ_UNJAM ##1 st_reg == czj_pkg::CZJ_FWD_WAIT);
   COV_CLEAR_ZERO: cover property (
      st_reg == czj_pkg::CZJ_CLEAR && timers.clear_set == 8'h00
      ##1 st_reg == czj_pkg::CZJ_IDLE);
   COV_TRANSFER: cover property (
      st_reg == czj_pkg::CZJ_CLEAR ##1 st_reg == czj_pkg::CZJ_IDLE);

endmodule // czj_zone

// ### hdl/czj_defines.svh
`ifndef CZJ_DEFINES_SVH
`define CZJ_DEFINES_SVH

// ***************************************************************
// timer settings
// ***************************************************************
`define CZJ_TMR_W          8
`define CZJ_TMR_ZERO       8'h00
`define CZJ_TMR_ONE        8'h01

// ***************************************************************
// timing: one timer step is 0.2 s, clock period 100 ns
// ***************************************************************
`define CZJ_CLK_PERIOD_NS  100
`define CZJ_TICK_NS        200000000
`define CZJ_TICK_CYCLES    (`CZJ_TICK_NS / `CZJ_CLK_PERIOD_NS)
`define CZJ_TICK_CNT_W     21
`define CZJ_TICK_CNT_ZERO  21'h000000

// ***************************************************************
// reset values and state width
// ***************************************************************
`define CZJ_SYNC_RST       2'h0
`define CZJ_STATE_W        3

`endif

// ### hdl/czj_pkg.sv
`include "czj_defines.svh"

package czj_pkg;

   // zone sequencer states
   typedef enum logic [`CZJ_STATE_W-1:0] {
      CZJ_IDLE      = 3'h0,
      CZJ_FWD_WAIT  = 3'h1,
      CZJ_FWD_BLOCK = 3'h2,
      CZJ_CLEAR     = 3'h3,
      CZJ_UNJAM     = 3'h4,
      CZJ_JAMMED    = 3'h5
   } czj_state_e;

   // programmed durations, in 0.2 s steps, zero disables
   typedef struct packed {
      logic [`CZJ_TMR_W-1:0] clear_set;
      logic [`CZJ_TMR_W-1:0] jam_set;
      logic [`CZJ_TMR_W-1:0] unjam_set;
   } czj_timers_s;

   // host jog request
   typedef struct packed {
      logic fwd;
      logic rev;
   } czj_jog_s;

endpackage

// ### hdl/czj_tick_gen.sv
`timescale 1ns/1ps
`include "czj_defines.svh"

module czj_tick_gen #(
   parameter int unsigned TICK_CYCLES = `CZJ_TICK_CYCLES
) (
   input  wire logic ref_clk,
   input  wire logic nrst,
   input  wire logic clk_en,
   output logic      tick
);

   localparam logic [`CZJ_TICK_CNT_W-1:0] LAST =
      `CZJ_TICK_CNT_W'(TICK_CYCLES - 1);

   logic [`CZJ_TICK_CNT_W-1:0] div_reg;
   logic [`CZJ_TICK_CNT_W-1:0] div_next;
   logic                       tick_reg;
   logic                       tick_next;

   // free-running divider, one pulse per timer step
   always_comb begin
      div_next  = div_reg + `CZJ_TICK_CNT_W'(1);
      tick_next = 1'b0;
      if (div_reg == LAST) begin
         div_next  = `CZJ_TICK_CNT_ZERO;
         tick_next = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         div_reg  <= `CZJ_TICK_CNT_ZERO;
         tick_reg <= 1'b0;
      end else if (clk_en) begin
         div_reg  <= div_next;
         tick_reg <= tick_next;
      end
   end

   assign tick = tick_reg;

endmodule // czj_tick_gen

// ### tb/czj_tray_model.sv
`timescale 1ns/1ps

// ***************************************************************
// tray and sensor standing at one zone
// ***************************************************************
module czj_tray_model (
   input  wire logic ref_clk,
   input  wire logic nrst,
   input  wire logic sensor_act_high,
   input  wire logic motor_rev,
   input  wire logic tray_here,
   input  wire logic slip_free,
   output logic      sensor_pin
);
   logic freed_reg;
   logic freed_next;
   logic blocked;

   // a reversed tray slips off the sensor only when the bench asks
   always_comb begin
      freed_next = freed_reg;
      if (!tray_here)
         freed_next = 1'b0;
      else if (motor_rev && slip_free)
         freed_next = 1'b1;
   end

   // freed state survives until the tray is taken away
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst)
         freed_reg <= 1'b0;
      else
         freed_reg <= freed_next;
   end

   // pin level follows the configured sensor polarity
   assign blocked    = tray_here && !freed_reg;
   assign sensor_pin = sensor_act_high ? blocked : !blocked;
endmodule // czj_tray_model

// ### tb/czj_zone_bench.sv
`timescale 1ns/1ps

// ***************************************************************
// self-checking bench for one conveyor zone
// ***************************************************************
module czj_zone_bench;
   localparam int TICKS = 4;
   localparam int CEIL  = 3000;

   logic                 ref_clk = 1'b0;
   logic                 nrst = 1'b0;
   logic                 clk_en = 1'b1;
   logic                 sensor_act_high = 1'b1;
   logic                 run_req = 1'b0;
   logic                 tray_here = 1'b0;
   logic                 slip_free = 1'b0;
   logic                 sensor_pin;
   czj_pkg::czj_jog_s    jog = 2'h0;
   czj_pkg::czj_timers_s timers = 24'h000000;
   logic                 motor_fwd;
   logic                 motor_rev;
   logic                 jam_flag;
   czj_pkg::czj_state_e  zone_state;
   logic [2:0]           seen;
   int                   err_total = 0;
   int                   check_count = 0;
   int                   cyc_count = 0;

   // fast tick keeps every timer within a few dozen cycles
   czj_zone #(.TICK_CYCLES(TICKS)) dut (
      .ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en),
      .sensor_pin(sensor_pin), .sensor_act_high(sensor_act_high),
      .run_req(run_req), .jog(jog), .timers(timers),
      .motor_fwd(motor_fwd), .motor_rev(motor_rev),
      .jam_flag(jam_flag), .zone_state(zone_state));

   czj_tray_model tray (
      .ref_clk(ref_clk), .nrst(nrst),
      .sensor_act_high(sensor_act_high), .motor_rev(motor_rev),
      .tray_here(tray_here), .slip_free(slip_free),
      .sensor_pin(sensor_pin));

   assign seen = {motor_fwd, motor_rev, jam_flag};

   // clock, 100 ns period
   always #50 ref_clk = ~ref_clk;

   // hang guard
   always @(posedge ref_clk) begin
      cyc_count++;
      if (cyc_count == CEIL) begin
         err_total++;
         stop_test();
      end
   end

   // ***************************************************************
   // compare and wait tasks
   // ***************************************************************
   task automatic chk_out(input logic [2:0] got, input logic [2:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // a response earlier than its timer allows is as wrong as a late one
   task automatic chk_lat(input int got, input int lo);
      check_count++;
      if (got < lo) begin
         err_total++;
         $display("unexpected at %0t got %h exp %h", $time, got, lo);
      end
   endtask

   // sequencer state, so a right motor level in a wrong state is caught
   task automatic chk_st(input logic [2:0] exp);
      check_count++;
      if (zone_state !== exp) begin
         err_total++;
         $display("unexpected at %0t got %h exp %h", $time, zone_state, exp);
      end
   endtask

   task automatic expect_in(input logic [2:0] exp, input int lo, input int hi);
      int i;
      for (i = 0; i < hi; i++) begin
         @(posedge ref_clk);
         #1;
         if (seen === exp)
            break;
      end
      chk_out(seen, exp);
      chk_lat(i, lo);
   endtask

   task automatic hold(input logic [2:0] exp, input int n);
      repeat (n) begin
         @(posedge ref_clk);
         #1;
         chk_out(seen, exp);
      end
   endtask

   task automatic start(input logic [7:0] c, input logic [7:0] j,
                        input logic [7:0] u);
      @(posedge ref_clk);
      timers  <= {c, j, u};
      run_req <= 1'b1;
      expect_in(3'h4, 0, 4);
      @(posedge ref_clk);
      tray_here <= 1'b1;
   endtask

   task automatic leave(input string name);
      @(posedge ref_clk);
      tray_here <= 1'b0;
      run_req   <= 1'b0;
      jog       <= 2'h0;
      expect_in(3'h0, 0, 16);
      $display("test %s done", name);
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // ***************************************************************
   // test sequence
   // ***************************************************************
   initial begin
      repeat (5) @(posedge ref_clk);
      nrst <= 1'b1;
      #1;
      chk_out(seen, 3'h0);
      hold(3'h0, 3);

      // short tray passes, clear timer then stops the motor
      start(8'h02, 8'h05, 8'h02);
      hold(3'h4, 8);
      chk_st(czj_pkg::CZJ_FWD_BLOCK);
      leave("transfer");

      // held tray, reversal fails, zone ends jammed
      start(8'h02, 8'h03, 8'h02);
      expect_in(3'h3, 8, 20);
      expect_in(3'h1, 3, 12);
      hold(3'h1, 4);
      // enable low: a removed tray must go unseen, jam stays put
      @(posedge ref_clk);
      clk_en    <= 1'b0;
      tray_here <= 1'b0;
      hold(3'h1, 6);
      chk_st(czj_pkg::CZJ_JAMMED);
      @(posedge ref_clk);
      clk_en <= 1'b1;
      leave("jam");

      // reversal frees the tray and forward motion returns
      slip_free <= 1'b1;
      start(8'h02, 8'h03, 8'h02);
      expect_in(3'h3, 8, 20);
      expect_in(3'h4, 0, 8);
      chk_st(czj_pkg::CZJ_FWD_WAIT);
      slip_free <= 1'b0;
      leave("unjam");

      // no reversal, inverted sensor polarity
      // synchroniser holds the old level; let it settle while idle
      @(posedge ref_clk);
      sensor_act_high <= 1'b0;
      hold(3'h0, 3);
      start(8'h02, 8'h03, 8'h00);
      expect_in(3'h1, 8, 20);
      chk_st(czj_pkg::CZJ_JAMMED);
      leave("no reversal");
      @(posedge ref_clk);
      sensor_act_high <= 1'b1;
      hold(3'h0, 3);

      // jam detection switched off
      start(8'h02, 8'h00, 8'h02);
      hold(3'h4, 40);
      chk_st(czj_pkg::CZJ_FWD_BLOCK);
      leave("no jam");

      // two touching trays with clear timer at zero
      start(8'h00, 8'h05, 8'h02);
      hold(3'h4, 4);
      @(posedge ref_clk);
      tray_here <= 1'b0;
      run_req   <= 1'b0;
      hold(3'h4, 8);
      @(posedge ref_clk);
      tray_here <= 1'b1;
      expect_in(3'h0, 2, 5);
      chk_st(czj_pkg::CZJ_IDLE);
      leave("touching");

      // host jog on a blocked sensor never jams
      @(posedge ref_clk);
      timers    <= {8'h02, 8'h02, 8'h02};
      tray_here <= 1'b1;
      jog       <= 2'h2;
      expect_in(3'h4, 0, 3);
      hold(3'h4, 30);
      chk_st(czj_pkg::CZJ_IDLE);
      @(posedge ref_clk);
      jog <= 2'h1;
      expect_in(3'h2, 0, 3);
      leave("jog");
      stop_test();
   end
endmodule // czj_zone_bench
